// *** hw/sram_host.sv ***
// host controller for an asynchronous 2M x 16 static ram with byte lanes
// assumes the memory pins are wired straight to the outputs; data pin is split in/out/oe
// assumes the memory's supply is at level when reset is released
module sram_host (
   // clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   resetn,
   // user side
   input  wire sram_host_pkg::req_t                    req,
   input  wire logic                                   req_valid,
   output logic                                        req_ready,
   output logic                                        rd_valid,
   output logic [sram_host_pkg::DATA_W-1:0]            rd_data,
   // memory pins
   output sram_host_pkg::strobes_t                     mem_strobes,
   output logic [sram_host_pkg::ADDR_W-1:0]            mem_addr,
   output logic [sram_host_pkg::DATA_W-1:0]            mem_data_out,
   output logic                                        mem_data_oe,
   input  wire logic [sram_host_pkg::DATA_W-1:0]       mem_data_in
);
   // pins at rest: deselected, outputs off, no strobe, no lane
   localparam sram_host_pkg::strobes_t IDLE_STROBES = 5'h1F;

   // sequencer state and its wait counter
   sram_host_pkg::state_t                   state;
   sram_host_pkg::state_t                   next_state;
   // counter wide enough for the power-up wait
   logic [sram_host_pkg::CNT_W-1:0]         cnt;
   logic [sram_host_pkg::CNT_W-1:0]         next_cnt;
   // next values of the registered outputs
   logic                                    next_req_ready;
   logic                                    next_rd_valid;
   logic [sram_host_pkg::DATA_W-1:0]        next_rd_data;
   logic [sram_host_pkg::DATA_W-1:0]        next_mem_data_out;
   sram_host_pkg::strobes_t                 next_mem_strobes;
   logic [sram_host_pkg::ADDR_W-1:0]        next_mem_addr;
   logic                                    next_mem_data_oe;
   // lanes of the access in flight, kept for masking the read word
   logic [1:0]                              lanes_q;
   logic [1:0]                              next_lanes_q;
   // capture stages of the data pins
   logic [sram_host_pkg::DATA_W-1:0]        din_meta;
   logic [sram_host_pkg::DATA_W-1:0]        din_sync;
   logic [sram_host_pkg::DATA_W-1:0]        next_din_meta;
   logic [sram_host_pkg::DATA_W-1:0]        next_din_sync;

   // two-stage capture of the asynchronous data pins
   // the memory has no clock of its own, so its bus is handled like any pin;
   // only the second stage is read by the sequencer
   // the first stage may go metastable; nothing else may read it
   // trade-off: two cycles of latency on every read for a clean sample
   always_comb begin
      next_din_meta = mem_data_in;
      next_din_sync = din_meta;
   end

   // capture registers need no reset: nothing reads them outside a read wait
   always_ff @(posedge core_clk) begin
      din_meta <= next_din_meta;
      din_sync <= next_din_sync;
   end

   // sequencer next values
   // a request is taken only in idle, where ready is high
   // counted from the edge that takes a request:
   //    read   c0 select, output enable, lanes and address go out
   //           c6 word registered, rd_valid pulses, strobes rise
   //           c7 pins quiet while the memory lets go of the bus
   //           c8 ready again
   //    write  c0 select, write strobe, lanes, address and data go out
   //           c3 all strobes rise in one edge, data still driven
   //           c4 data driver released
   //           c5 ready again
   // fixed counts rounded up to whole cycles cost a few ns per access,
   // but need no answer from the memory
   always_comb begin
      // hold by default; the one-cycle pulses fall back to low
      next_state        = state;
      next_cnt          = cnt;
      next_req_ready    = 1'b0;
      next_rd_valid     = 1'b0;
      next_rd_data      = rd_data;
      next_mem_strobes  = mem_strobes;
      next_mem_addr     = mem_addr;
      next_mem_data_out = mem_data_out;
      next_mem_data_oe  = mem_data_oe;
      next_lanes_q      = lanes_q;
      case (state)
         sram_host_pkg::ST_POWER_UP: begin
            // no access until the supply has settled
            // the count starts at reset release; requests are not looked at yet
            // ready rises with the edge that leaves this state
            if (cnt == sram_host_pkg::CNT_W'(sram_host_pkg::POWER_UP_CYC - 1)) begin
               next_state     = sram_host_pkg::ST_IDLE;
               next_req_ready = 1'b1;
               next_cnt       = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         sram_host_pkg::ST_IDLE: begin
            next_req_ready = 1'b1;
            // empty lane set is dropped: it would neither read nor write
            // the requester sees no sign of it, so it must not expect an answer
            if (req_valid && req_ready && req.lanes != sram_host_pkg::LANES_NONE) begin
               // address and lanes stand for the whole access
               next_req_ready   = 1'b0;
               next_mem_addr    = req.addr;
               next_lanes_q     = req.lanes;
               next_cnt         = '0;
               next_mem_strobes.chip_sel_n          = 1'b0;
               next_mem_strobes.lower_lane_enable_n = ~req.lanes[0];
               next_mem_strobes.upper_lane_enable_n = ~req.lanes[1];
               if (req.write) begin
                  // oe stays high so the memory never drives against us
                  next_mem_strobes.write_n = 1'b0;
                  // data goes out with the strobe, so setup spans the whole pulse
                  next_mem_data_out = req.wdata;
                  next_mem_data_oe  = 1'b1;
                  next_state        = sram_host_pkg::ST_WRITE;
               end else begin
                  // write strobe stays high, so the memory drives only here
                  next_mem_strobes.out_en_n = 1'b0;
                  next_state = sram_host_pkg::ST_READ;
               end
            end
         end
         sram_host_pkg::ST_READ: begin
            next_cnt = cnt + 1'b1;
            // strobes stand unchanged while the count runs
            if (cnt == sram_host_pkg::CNT_W'(sram_host_pkg::ACCESS_CYC + 1)) begin
               // extra two cycles cover the input synchroniser
               // a lane left disabled reads as zero, never as a floating pin
               next_rd_data[7:0]  = lanes_q[0] ? din_sync[7:0]  : 8'h00;
               next_rd_data[15:8] = lanes_q[1] ? din_sync[15:8] : 8'h00;
               next_rd_valid      = 1'b1;
               // the strobes rise in the same edge as the word is taken
               next_mem_strobes   = IDLE_STROBES;
               next_cnt           = '0;
               next_state         = sram_host_pkg::ST_TURN;
            end
         end
         sram_host_pkg::ST_WRITE: begin
            next_cnt = cnt + 1'b1;
            // the low time covers the minimum write pulse
            if (cnt == sram_host_pkg::CNT_W'(sram_host_pkg::WR_PULSE_CYC - 1)) begin
               // all strobes rise together; data held one more cycle past that edge
               // one edge ends the write, so the data hold does not depend on
               // which strobe the memory sees rise first
               next_mem_strobes = IDLE_STROBES;
               next_cnt         = '0;
               next_state       = sram_host_pkg::ST_TURN;
            end
         end
         sram_host_pkg::ST_TURN: begin
            // our data driver lets go one cycle after the strobes
            next_mem_data_oe = 1'b0;
            next_cnt = cnt + 1'b1;
            // let the memory's drivers reach high-z before the next access
            // a read that follows at once would otherwise meet the tail of
            // this access on the bus
            if (cnt == sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYC - 1)) begin
               next_cnt       = '0;
               next_req_ready = 1'b1;
               next_state     = sram_host_pkg::ST_IDLE;
            end
         end
         default: begin
            // an unused code parks the pins and returns to idle
            next_state       = sram_host_pkg::ST_IDLE;
            next_mem_strobes = IDLE_STROBES;
            next_mem_data_oe = 1'b0;
         end
      endcase
   end

   // sequencer registers
   // reset parks the pins deselected, which puts the memory in standby;
   // ready stays low until the power-up wait has run out
   // no clock enable: every register loads on every edge
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state        <= sram_host_pkg::ST_POWER_UP;
         cnt          <= '0;
         req_ready    <= 1'b0;
         rd_valid     <= 1'b0;
         rd_data      <= '0;
         mem_strobes  <= IDLE_STROBES;
         mem_addr     <= '0;
         mem_data_out <= '0;
         mem_data_oe  <= 1'b0;
         lanes_q      <= '0;
      end else begin
         // next values are complete for every state
         state        <= next_state;
         cnt          <= next_cnt;
         req_ready    <= next_req_ready;
         rd_valid     <= next_rd_valid;
         rd_data      <= next_rd_data;
         mem_strobes  <= next_mem_strobes;
         mem_addr     <= next_mem_addr;
         mem_data_out <= next_mem_data_out;
         mem_data_oe  <= next_mem_data_oe;
         lanes_q      <= next_lanes_q;
      end
   end
endmodule : sram_host

// *** hw/sram_host_pkg.sv ***
// package for the asynchronous static ram host controller
// assumes a single 250 MHz core clock and a 2M x 16 asynchronous memory on the pins
package sram_host_pkg;
   localparam int          ADDR_W          = 21;
   localparam int          DATA_W          = 16;
   localparam int          LANE_W          = 8;
   localparam int          CLK_PERIOD_PS   = 4000;
   // read: address/select to data valid, 12 ns max, sample after it
   localparam int          ACCESS_NS       = 12;
   localparam int          ACCESS_CYC      = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   // write strobe low time, 9 ns min
   localparam int          WR_PULSE_NS     = 9;
   localparam int          WR_PULSE_CYC    = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // bus turnaround after deselect, 7 ns high-z max
   localparam int          TURN_NS         = 7;
   localparam int          TURN_CYC        = (TURN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // power-up wait, 100 us min
   localparam int          POWER_UP_US     = 100;
   localparam int          POWER_UP_CYC    = (POWER_UP_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int          CNT_W           = 16;
   localparam logic [1:0]  LANES_NONE      = 2'h0;

   typedef enum logic [2:0] {
      ST_POWER_UP = 3'h0,
      ST_IDLE     = 3'h1,
      ST_READ     = 3'h2,
      ST_WRITE    = 3'h3,
      ST_TURN     = 3'h4
   } state_t;

   // user request: lanes[0] lower byte, lanes[1] upper byte
   typedef struct packed {
      logic                write;
      logic [1:0]          lanes;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } req_t;

   // memory strobes, all active low
   typedef struct packed {
      logic                chip_sel_n;
      logic                out_en_n;
      logic                write_n;
      logic                lower_lane_enable_n;
      logic                upper_lane_enable_n;
   } strobes_t;
endpackage : sram_host_pkg

// *** tb/sram_host_checker.sv ***
// assertions on the pins and user side of the static ram host controller
// assumes it is bound to sram_host and sees only its ports
module sram_host_checker (
   input wire logic                    core_clk,
   input wire logic                    resetn,
   input wire sram_host_pkg::req_t     req,
   input wire logic                    req_valid,
   input wire logic                    req_ready,
   input wire logic                    rd_valid,
   input wire sram_host_pkg::strobes_t mem_strobes,
   input wire logic [20:0]             mem_addr,
   input wire logic [15:0]             mem_data_out,
   input wire logic                    mem_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] up_cnt;
   logic [15:0] next_up_cnt;
   logic        take;
   assign take = req_valid && req_ready;
   // cycles since reset release, saturating so a long run cannot wrap
   always_comb begin
      next_up_cnt = (up_cnt == 16'hFFFF) ? up_cnt : up_cnt + 16'h0001;
      if (!resetn) next_up_cnt = 16'h0000;
   end
   always_ff @(posedge core_clk) begin
      up_cnt <= next_up_cnt;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_read_strobes;
      take && !req.write && req.lanes == 2'h3 |=> mem_strobes == 5'h04 && mem_addr == $past(req.addr);
   endproperty
   a_read_strobes: assert property (p_read_strobes) else $error("read strobes wrong");
   property p_read_answer;
      take && !req.write && req.lanes != 2'h0 |-> ##[6:7] rd_valid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data late");
   property p_no_clash;
      !mem_strobes.out_en_n |-> !mem_data_oe;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("bus driven while device outputs");
   property p_write_strobes;
      take && req.write && req.lanes != 2'h0 |=> !mem_strobes.chip_sel_n && !mem_strobes.write_n
         && mem_data_oe && {mem_strobes.lower_lane_enable_n, mem_strobes.upper_lane_enable_n}
         == ~{$past(req.lanes[0]), $past(req.lanes[1])};
   endproperty
   a_write_strobes: assert property (p_write_strobes) else $error("write strobes wrong");
   property p_empty_ignored;
      take && req.lanes == 2'h0 |=> mem_strobes.chip_sel_n;
   endproperty
   a_empty_ignored: assert property (p_empty_ignored) else $error("empty lanes selected");
   property p_data_hold;
      $rose(mem_strobes.write_n) |-> mem_data_oe && $stable(mem_data_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data not held");
   property p_power_up;
      req_ready || !mem_strobes.chip_sel_n |-> up_cnt >= sram_host_pkg::POWER_UP_CYC - 1;
   endproperty
   a_power_up: assert property (p_power_up) else $error("access before power-up wait");
endmodule : sram_host_checker
bind sram_host sram_host_checker chk_u (.core_clk(core_clk), .resetn(resetn), .req(req),
   .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
   .mem_strobes(mem_strobes), .mem_addr(mem_addr), .mem_data_out(mem_data_out),
   .mem_data_oe(mem_data_oe));

// *** tb/sram_dev_model.sv ***
// behavioural 2M x 16 asynchronous static ram with byte lanes
// assumes active-low strobes; the bench resolves the shared data bus
module sram_dev_model (
   input  wire sram_host_pkg::strobes_t s,
   input  wire logic [20:0]             addr,
   input  wire logic [15:0]             din,
   output logic [15:0]                  dout,
   output logic [1:0]                   drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:(1 << 21) - 1];
   assign dout = mem[addr];
   // level sensitive: the write follows the overlap, any release ends it
   always @(s or addr or din) begin
      if (!s.chip_sel_n && !s.write_n && !s.lower_lane_enable_n) mem[addr][7:0] = din[7:0];
      if (!s.chip_sel_n && !s.write_n && !s.upper_lane_enable_n) mem[addr][15:8] = din[15:8];
   end
   // lanes float unless selected, output enabled and not writing
   always_comb begin
      drive = 2'h0;
      if (!s.chip_sel_n && !s.out_en_n && s.write_n) begin
         drive = ~{s.upper_lane_enable_n, s.lower_lane_enable_n};
      end
   end
endmodule : sram_dev_model

// *** tb/sram_host_tb.sv ***
// bench for the static ram host controller
// assumes the device model on the pins and a 250 MHz core clock
module sram_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, req_valid, req_ready, rd_valid, mem_data_oe;
   sram_host_pkg::req_t req;
   sram_host_pkg::strobes_t mem_strobes;
   logic [20:0] mem_addr;
   logic [15:0] rd_data, mem_data_out, mem_data_in, dout, q;
   logic [1:0] drive;
   int miscompares = 0, cmp_count = 0, ticks = 0;
   localparam logic [20:0] TOP = 21'h1FFFFF;
   sram_host dut_u (.core_clk(core_clk), .resetn(resetn), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .mem_strobes(mem_strobes),
      .mem_addr(mem_addr), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
      .mem_data_in(mem_data_in));
   sram_dev_model sram_u (.s(mem_strobes), .addr(mem_addr), .din(mem_data_out), .dout(dout),
      .drive(drive));
   // released lanes show a moving pattern so a stale value cannot pass
   assign mem_data_in = mem_data_oe ? mem_data_out :
      {drive[1] ? dout[15:8] : ~ticks[7:0], drive[0] ? dout[7:0] : ticks[7:0]};
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // hang guard, well past power-up plus the few accesses
   always @(posedge core_clk) begin
      ticks <= ticks + 1;
      if (ticks == 40000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one request, held until taken, then wait for data and ready again
   task automatic access(logic wr, logic [1:0] ln, logic [20:0] a, logic [15:0] d);
      int n;
      n = 0;
      req = '{wr, ln, a, d};
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n++ < 100) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
      req_valid = 1'b0;
      n = 0;
      while ((n < 2 || req_ready !== 1'b1) && n++ < 30) begin
         if (rd_valid === 1'b1) q = rd_data;
         @(posedge core_clk) #1;
      end
   endtask : access
   task automatic t_power_up();
      repeat (24990) @(posedge core_clk);
      #1 chk("ready_early", {15'h0, req_ready}, 16'h0000);
      chk("select_early", {15'h0, mem_strobes.chip_sel_n}, 16'h0001);
   endtask : t_power_up
   task automatic t_full();
      access(1'b1, 2'h3, TOP, 16'hA55A);
      chk("mem_all", sram_u.mem[TOP], 16'hA55A);
      access(1'b0, 2'h3, TOP, 16'h0000);
      chk("rd_all", q, 16'hA55A);
   endtask : t_full
   task automatic t_lanes();
      access(1'b1, 2'h1, TOP, 16'h1234);
      chk("mem_lo", sram_u.mem[TOP], 16'hA534);
      access(1'b0, 2'h2, TOP, 16'h0000);
      chk("rd_hi", q, 16'hA500);
      access(1'b1, 2'h2, TOP, 16'hBEEF);
      chk("mem_hi", sram_u.mem[TOP], 16'hBE34);
      access(1'b0, 2'h1, TOP, 16'h0000);
      chk("rd_lo", q, 16'h0034);
      access(1'b1, 2'h0, TOP, 16'h0000);
      chk("mem_empty", sram_u.mem[TOP], 16'hBE34);
   endtask : t_lanes
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (2) @(posedge core_clk);
      #1 resetn = 1'b1;
      t_power_up();
      t_full();
      t_lanes();
      wrap_up();
   end
endmodule : sram_host_tb
